// ---- rtl/cbto_pkg.sv ----
package cbto_pkg;
   // Operation classes after decode
   typedef enum logic [4:0] {
      CBTO_OP_NOP,
      CBTO_OP_IO_CLR,
      CBTO_OP_IO_SET,
      CBTO_OP_BST,
      CBTO_OP_BLD,
      CBTO_OP_FLAG_SET,
      CBTO_OP_FLAG_CLR,
      CBTO_OP_MOV,
      CBTO_OP_LDI,
      CBTO_OP_LD,
      CBTO_OP_LD_INC,
      CBTO_OP_LD_DEC,
      CBTO_OP_ST,
      CBTO_OP_ST_INC,
      CBTO_OP_ST_DEC,
      CBTO_OP_LDS,
      CBTO_OP_STS,
      CBTO_OP_IN,
      CBTO_OP_OUT,
      CBTO_OP_PUSH,
      CBTO_OP_POP,
      CBTO_OP_BREAK,
      CBTO_OP_SLEEP,
      CBTO_OP_WDR
   } cbto_op_t;

   // Decoded instruction as presented by the fetch stage
   typedef struct packed {
      cbto_op_t   op;
      logic [3:0] rd;
      logic [3:0] rr;
      logic [2:0] bitsel;
      logic [1:0] ptr;
      logic [7:0] imm;
      logic [5:0] io_addr;
      logic [7:0] mem_addr;
   } cbto_instr_t;

   // Data memory port request
   typedef struct packed {
      logic       rd_en;
      logic       wr_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cbto_mem_req_t;

   // I/O space request
   typedef struct packed {
      logic       rd_en;
      logic       wr_en;
      logic [5:0] addr;
      logic [7:0] wdata;
   } cbto_io_req_t;

   localparam int unsigned CBTO_NREGS     = 16;
   localparam logic [3:0]  CBTO_PTR_X_LO  = 4'hA;
   localparam logic [3:0]  CBTO_PTR_Y_LO  = 4'hC;
   localparam logic [3:0]  CBTO_PTR_Z_LO  = 4'hE;
   localparam logic [7:0]  CBTO_STATUS_REGISTER_RST  = 8'h00;
   localparam logic [7:0]  CBTO_SP_RST    = 8'hFF;
   localparam logic [7:0]  CBTO_REG_RST   = 8'h00;
   // Status bit positions
   localparam int unsigned CBTO_FLAG_C    = 0;
   localparam int unsigned CBTO_FLAG_Z    = 1;
   localparam int unsigned CBTO_FLAG_N    = 2;
   localparam int unsigned CBTO_FLAG_V    = 3;
   localparam int unsigned CBTO_FLAG_S    = 4;
   localparam int unsigned CBTO_FLAG_H    = 5;
   localparam int unsigned CBTO_FLAG_T    = 6;
   localparam int unsigned CBTO_FLAG_I    = 7;
   // Cycle counts
   localparam logic [1:0]  CBTO_CYC_ONE   = 2'h1;
   localparam logic [1:0]  CBTO_CYC_TWO   = 2'h2;
   localparam logic [1:0]  CBTO_CYC_THREE = 2'h3;
endpackage : cbto_pkg

// ---- rtl/cbto_ptr_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
// Pointer pair adjust: post-increment or pre-decrement
module cbto_ptr_unit (
   // Pointer in
   input  wire logic [15:0] ptr_in,
   input  wire logic        inc,
   input  wire logic        dec,
   // Results
   output logic      [15:0] addr_use,
   output logic      [15:0] ptr_next
);
   logic [15:0] ptr_dec;

   assign ptr_dec  = ptr_in - 16'h0001;
   assign addr_use = dec ? ptr_dec : ptr_in;
   assign ptr_next = inc ? ptr_in + 16'h0001 : (dec ? ptr_dec : ptr_in);
endmodule : cbto_ptr_unit
`default_nettype wire

// ---- rtl/cbto_core.sv ----
// What this block does
// - Clear selected I/O bit in one cycle; flags untouched.
// - Copy selected register bit into transfer flag in one cycle.
// - Write transfer flag into selected register bit in one cycle.
// - Each flag instruction sets or clears exactly one status flag, one cycle.
// - Overflow clear zeroes overflow flag in one cycle, others kept.
// - Post-increment load reads at pointer, then increments it; two cycles.
// - Pre-decrement load decrements pointer, then reads; two cycles.
// - Post-increment store writes at pointer, increments it; one cycle.
// - Pre-decrement store decrements pointer, then writes; two cycles.
// - Direct load fetches byte at immediate address; one cycle.
// - Direct store writes register at immediate address; one cycle.
// - I/O in and out move one byte in one cycle, no flags.
// - Push places register on stack in two cycles, no flags.
// - Pop fetches top stack byte into register in two cycles.
// - Break, nop, sleep, watchdog restart take one cycle, no flags.
`timescale 1ns/10ps
`default_nettype none
module cbto_core (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   // Instruction issue
   input  wire logic                    instr_valid,
   input  wire cbto_pkg::cbto_instr_t   instr,
   output logic                         instr_ready,
   // Data memory
   output var cbto_pkg::cbto_mem_req_t  mem_req,
   input  wire logic [7:0]              mem_rdata,
   // I/O space
   output var cbto_pkg::cbto_io_req_t   io_req,
   input  wire logic [7:0]              io_rdata,
   // Control events and state
   output logic                         break_pulse,
   output logic                         sleep_pulse,
   output logic                         wdr_pulse,
   output logic [7:0]                   status_register,
   output logic [7:0]                   stack_ptr
);
   typedef enum logic [1:0] {CBTO_S_IDLE, CBTO_S_EXEC, CBTO_S_DONE} cbto_state_t;

   cbto_state_t           state_q;
   cbto_pkg::cbto_instr_t cur_q;
   logic [1:0]            cyc_q;
   logic [1:0]            cyc_need;
   logic [7:0]            regs_q [cbto_pkg::CBTO_NREGS];
   logic [7:0]            status_register_q;
   logic [7:0]            sp_q;
   logic [15:0]           ptr_val;
   logic [15:0]           ptr_addr;
   logic [15:0]           ptr_next;
   logic [3:0]            ptr_lo;
   logic                  is_inc;
   logic                  is_dec;
   logic                  last;
   logic [7:0]            rd_val;
   logic [7:0]            rr_val;
   logic [7:0]            bit_mask;

   // Pointer register index from pointer select
   function automatic logic [3:0] ptr_base(input logic [1:0] sel);
      case (sel)
         2'h0:    ptr_base = cbto_pkg::CBTO_PTR_X_LO;
         2'h1:    ptr_base = cbto_pkg::CBTO_PTR_Y_LO;
         default: ptr_base = cbto_pkg::CBTO_PTR_Z_LO;
      endcase
   endfunction : ptr_base

   // Cycle count for each operation
   function automatic logic [1:0] op_cycles(input cbto_pkg::cbto_op_t op);
      case (op)
         cbto_pkg::CBTO_OP_LD_INC: op_cycles = cbto_pkg::CBTO_CYC_TWO;
         cbto_pkg::CBTO_OP_LD_DEC: op_cycles = cbto_pkg::CBTO_CYC_TWO;
         cbto_pkg::CBTO_OP_LD:     op_cycles = cbto_pkg::CBTO_CYC_ONE;
         cbto_pkg::CBTO_OP_ST_DEC: op_cycles = cbto_pkg::CBTO_CYC_TWO;
         cbto_pkg::CBTO_OP_PUSH:   op_cycles = cbto_pkg::CBTO_CYC_TWO;
         cbto_pkg::CBTO_OP_POP:    op_cycles = cbto_pkg::CBTO_CYC_TWO;
         default:                  op_cycles = cbto_pkg::CBTO_CYC_ONE;
      endcase
   endfunction : op_cycles

   assign ptr_lo   = ptr_base(cur_q.ptr);
   assign ptr_val  = {regs_q[ptr_lo + 4'h1], regs_q[ptr_lo]};
   assign is_inc   = (cur_q.op == cbto_pkg::CBTO_OP_LD_INC) || (cur_q.op == cbto_pkg::CBTO_OP_ST_INC);
   assign is_dec   = (cur_q.op == cbto_pkg::CBTO_OP_LD_DEC) || (cur_q.op == cbto_pkg::CBTO_OP_ST_DEC);
   assign cyc_need = op_cycles(cur_q.op);
   assign last     = (state_q == CBTO_S_EXEC) && (cyc_q == cyc_need);
   assign rd_val   = regs_q[cur_q.rd];
   assign rr_val   = regs_q[cur_q.rr];
   assign bit_mask = 8'h01 << cur_q.bitsel;
   assign instr_ready = (state_q != CBTO_S_EXEC);

   cbto_ptr_unit u_ptr (
      .ptr_in   (ptr_val),
      .inc      (is_inc),
      .dec      (is_dec),
      .addr_use (ptr_addr),
      .ptr_next (ptr_next)
   );

   // Issue and cycle sequencing
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= CBTO_S_IDLE;
         cur_q   <= '0;
         cyc_q   <= 2'h0;
      end else begin
         case (state_q)
            CBTO_S_IDLE, CBTO_S_DONE: begin
               state_q <= CBTO_S_IDLE;
               if (instr_valid) begin
                  cur_q   <= instr;
                  cyc_q   <= cbto_pkg::CBTO_CYC_ONE;
                  state_q <= CBTO_S_EXEC;
               end
            end
            CBTO_S_EXEC: begin
               if (last) begin
                  state_q <= CBTO_S_DONE;
               end else begin
                  cyc_q <= cyc_q + 2'h1;
               end
            end
            default: state_q <= CBTO_S_IDLE;
         endcase
      end
   end

   // Memory and I/O requests, issued on the final cycle
   always_comb begin
      mem_req = '0;
      io_req  = '0;
      if (last) begin
         case (cur_q.op)
            cbto_pkg::CBTO_OP_IO_CLR, cbto_pkg::CBTO_OP_IO_SET: begin
               io_req.addr  = cur_q.io_addr;
               io_req.wr_en = 1'b1;
               io_req.wdata = (cur_q.op == cbto_pkg::CBTO_OP_IO_CLR) ? (io_rdata & ~bit_mask)
                                                                   : (io_rdata | bit_mask);
            end
            cbto_pkg::CBTO_OP_IN: begin
               io_req.addr  = cur_q.io_addr;
               io_req.rd_en = 1'b1;
            end
            cbto_pkg::CBTO_OP_OUT: begin
               io_req.addr  = cur_q.io_addr;
               io_req.wr_en = 1'b1;
               io_req.wdata = rr_val;
            end
            cbto_pkg::CBTO_OP_LD, cbto_pkg::CBTO_OP_LD_INC, cbto_pkg::CBTO_OP_LD_DEC: begin
               mem_req.addr  = ptr_addr[7:0];
               mem_req.rd_en = 1'b1;
            end
            cbto_pkg::CBTO_OP_ST, cbto_pkg::CBTO_OP_ST_INC, cbto_pkg::CBTO_OP_ST_DEC: begin
               mem_req.addr  = ptr_addr[7:0];
               mem_req.wr_en = 1'b1;
               mem_req.wdata = rr_val;
            end
            cbto_pkg::CBTO_OP_LDS: begin
               mem_req.addr  = cur_q.mem_addr;
               mem_req.rd_en = 1'b1;
            end
            cbto_pkg::CBTO_OP_STS: begin
               mem_req.addr  = cur_q.mem_addr;
               mem_req.wr_en = 1'b1;
               mem_req.wdata = rr_val;
            end
            cbto_pkg::CBTO_OP_PUSH: begin
               mem_req.addr  = sp_q;
               mem_req.wr_en = 1'b1;
               mem_req.wdata = rr_val;
            end
            cbto_pkg::CBTO_OP_POP: begin
               mem_req.addr  = sp_q + 8'h01;
               mem_req.rd_en = 1'b1;
            end
            default: begin
               mem_req = '0;
            end
         endcase
      end
   end

   // Register file, with pointer write-back
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < cbto_pkg::CBTO_NREGS; i++) begin
            regs_q[i] <= cbto_pkg::CBTO_REG_RST;
         end
      end else if (last) begin
         case (cur_q.op)
            cbto_pkg::CBTO_OP_BLD: regs_q[cur_q.rd] <= status_register_q[cbto_pkg::CBTO_FLAG_T] ? (rd_val | bit_mask)
                                                                                     : (rd_val & ~bit_mask);
            cbto_pkg::CBTO_OP_MOV: regs_q[cur_q.rd] <= rr_val;
            cbto_pkg::CBTO_OP_LDI: regs_q[cur_q.rd] <= cur_q.imm;
            cbto_pkg::CBTO_OP_IN:  regs_q[cur_q.rd] <= io_rdata;
            cbto_pkg::CBTO_OP_LD, cbto_pkg::CBTO_OP_LDS, cbto_pkg::CBTO_OP_POP: begin
               regs_q[cur_q.rd] <= mem_rdata;
            end
            cbto_pkg::CBTO_OP_LD_INC, cbto_pkg::CBTO_OP_LD_DEC: begin
               regs_q[ptr_lo]        <= ptr_next[7:0];
               regs_q[ptr_lo + 4'h1] <= ptr_next[15:8];
               // Loaded byte wins when destination overlaps pointer
               regs_q[cur_q.rd]      <= mem_rdata;
            end
            cbto_pkg::CBTO_OP_ST_INC, cbto_pkg::CBTO_OP_ST_DEC: begin
               regs_q[ptr_lo]        <= ptr_next[7:0];
               regs_q[ptr_lo + 4'h1] <= ptr_next[15:8];
            end
            default: regs_q[cur_q.rd] <= rd_val;
         endcase
      end
   end

   // Status register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         status_register_q <= cbto_pkg::CBTO_STATUS_REGISTER_RST;
      end else if (last) begin
         case (cur_q.op)
            cbto_pkg::CBTO_OP_BST:      status_register_q[cbto_pkg::CBTO_FLAG_T] <= rr_val[cur_q.bitsel];
            // Bit select names the flag: V clear, I set/clear included
            cbto_pkg::CBTO_OP_FLAG_SET: status_register_q[cur_q.bitsel] <= 1'b1;
            cbto_pkg::CBTO_OP_FLAG_CLR: status_register_q[cur_q.bitsel] <= 1'b0;
            default:                    status_register_q <= status_register_q;
         endcase
      end
   end

   // Stack pointer
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sp_q <= cbto_pkg::CBTO_SP_RST;
      end else if (last && cur_q.op == cbto_pkg::CBTO_OP_PUSH) begin
         sp_q <= sp_q - 8'h01;
      end else if (last && cur_q.op == cbto_pkg::CBTO_OP_POP) begin
         sp_q <= sp_q + 8'h01;
      end
   end

   // Control event pulses
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         break_pulse <= 1'b0;
         sleep_pulse <= 1'b0;
         wdr_pulse   <= 1'b0;
      end else begin
         break_pulse <= last && (cur_q.op == cbto_pkg::CBTO_OP_BREAK);
         sleep_pulse <= last && (cur_q.op == cbto_pkg::CBTO_OP_SLEEP);
         wdr_pulse   <= last && (cur_q.op == cbto_pkg::CBTO_OP_WDR);
      end
   end

   assign status_register = status_register_q;
   assign stack_ptr       = sp_q;
endmodule : cbto_core
`default_nettype wire

// ---- verification/cbto_core_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module cbto_core_checker (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  resetn,
   // Issue
   input wire logic                  instr_valid,
   input wire cbto_pkg::cbto_instr_t instr,
   input wire logic                  instr_ready,
   // Memory and I/O
   input wire cbto_pkg::cbto_mem_req_t mem_req,
   input wire logic [7:0]            mem_rdata,
   input wire cbto_pkg::cbto_io_req_t io_req,
   input wire logic [7:0]            io_rdata,
   // Events and state
   input wire logic                  break_pulse,
   input wire logic                  sleep_pulse,
   input wire logic                  wdr_pulse,
   input wire logic [7:0]            status_register,
   input wire logic [7:0]            stack_ptr
);
   wire logic take = instr_valid && instr_ready;
   wire logic two  = instr.op inside {cbto_pkg::CBTO_OP_LD_INC, cbto_pkg::CBTO_OP_LD_DEC,
                                      cbto_pkg::CBTO_OP_ST_DEC, cbto_pkg::CBTO_OP_PUSH, cbto_pkg::CBTO_OP_POP};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_two_cycle_ops: assert property (take && two |=> !instr_ready [*2] ##1 instr_ready)
      else $error("two cycle op length wrong");
   a_one_cycle_ops: assert property (take && !two |=> !instr_ready ##1 instr_ready)
      else $error("one cycle op length wrong");
   a_req_in_exec: assert property (mem_req.rd_en || mem_req.wr_en || io_req.rd_en || io_req.wr_en |-> !instr_ready)
      else $error("request outside execution");
   a_flag_set_one: assert property (take && instr.op == cbto_pkg::CBTO_OP_FLAG_SET |-> ##2
      status_register == ($past(status_register, 2) | (8'h01 << $past(instr.bitsel, 2))))
      else $error("flag set wrong");
   a_flag_clr_one: assert property (take && instr.op == cbto_pkg::CBTO_OP_FLAG_CLR |-> ##2
      status_register == ($past(status_register, 2) & ~(8'h01 << $past(instr.bitsel, 2))))
      else $error("flag clear wrong");
   a_io_clear_bit: assert property (take && instr.op == cbto_pkg::CBTO_OP_IO_CLR |=> io_req.wr_en
      && io_req.addr == $past(instr.io_addr) && io_req.wdata == (io_rdata & ~(8'h01 << $past(instr.bitsel))))
      else $error("io bit clear wrong");
   a_push_sp_dec: assert property (take && instr.op == cbto_pkg::CBTO_OP_PUSH |-> ##3
      stack_ptr == $past(stack_ptr, 3) - 8'h01)
      else $error("push stack pointer wrong");
   a_break_pulse: assert property (take && instr.op == cbto_pkg::CBTO_OP_BREAK |-> ##2 break_pulse
      && status_register == $past(status_register, 2))
      else $error("break pulse wrong");
   c_push: cover property (take && instr.op == cbto_pkg::CBTO_OP_PUSH);
   c_ld_dec: cover property (take && instr.op == cbto_pkg::CBTO_OP_LD_DEC);
   c_io_clr: cover property (take && instr.op == cbto_pkg::CBTO_OP_IO_CLR);
endmodule : cbto_core_checker
bind cbto_core cbto_core_checker u_chk (.ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid),
   .instr(instr), .instr_ready(instr_ready), .mem_req(mem_req), .mem_rdata(mem_rdata), .io_req(io_req),
   .io_rdata(io_rdata), .break_pulse(break_pulse), .sleep_pulse(sleep_pulse), .wdr_pulse(wdr_pulse),
   .status_register(status_register), .stack_ptr(stack_ptr));
`default_nettype wire

// ---- verification/test_cpu_bit_transfer_ops.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_cpu_bit_transfer_ops;
   logic                    ref_clk     = 1'b0;
   logic                    resetn      = 1'b0;
   logic                    instr_valid = 1'b0;
   cbto_pkg::cbto_instr_t   instr       = '0;
   logic [7:0]              mem_rdata   = 8'h00;
   logic [7:0]              io_rdata    = 8'h00;
   logic [7:0]              esr         = 8'h00;
   logic [31:0]             seed        = 32'h7730;
   logic                    instr_ready, break_pulse, sleep_pulse, wdr_pulse;
   logic [7:0]              status_register, stack_ptr, v, w, d;
   cbto_pkg::cbto_mem_req_t mem_req, mq;
   cbto_pkg::cbto_io_req_t  io_req, iq;
   logic [2:0]              pls;
   logic [3:0]              r, lo;
   int                      cyc, miscompares = 0, compares = 0;
   cbto_pkg::cbto_op_t      cop [4] = '{cbto_pkg::CBTO_OP_BREAK, cbto_pkg::CBTO_OP_SLEEP,
                                        cbto_pkg::CBTO_OP_WDR, cbto_pkg::CBTO_OP_NOP};
   always #2.5 ref_clk = ~ref_clk;
   cbto_core DUT (.ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .mem_req(mem_req), .mem_rdata(mem_rdata), .io_req(io_req), .io_rdata(io_rdata),
      .break_pulse(break_pulse), .sleep_pulse(sleep_pulse), .wdr_pulse(wdr_pulse),
      .status_register(status_register), .stack_ptr(stack_ptr));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // Issue one instruction at a falling edge, record requests and length
   task automatic go(input cbto_pkg::cbto_op_t op, input logic [3:0] ri, input logic [2:0] b, input logic [7:0] k,
                     input logic use_s = 1'b0, input logic [3:0] s = 4'h0);
      instr = '{op: op, rd: ri, rr: (use_s ? s : ri), bitsel: b, ptr: b[1:0], imm: k, io_addr: k[5:0], mem_addr: k};
      instr_valid = 1'b1;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      cyc = 0;
      mq = '0;
      iq = '0;
      while (instr_ready !== 1'b1 && cyc < 8) begin
         if (mem_req.rd_en || mem_req.wr_en) mq = mem_req;
         if (io_req.rd_en || io_req.wr_en) iq = io_req;
         cyc++;
         @(negedge ref_clk);
      end
      pls = {break_pulse, sleep_pulse, wdr_pulse};
   endtask : go
   task automatic peek(input logic [3:0] ri, input logic [7:0] e);
      go(cbto_pkg::CBTO_OP_STS, ri, 3'h0, 8'h5A);
      `CHK({mq.wr_en, mq.addr, mq.wdata, cyc[1:0], status_register}, {1'b1, 8'h5A, e, 2'h1, esr})
   endtask : peek
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   initial begin
      #100000;
      miscompares++;
      test_done();
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      resetn = 1'b1;
      `CHK({status_register, stack_ptr, instr_ready}, {8'h00, 8'hFF, 1'b1})
      for (int b = 0; b < 16; b++) begin
         go(b < 8 ? cbto_pkg::CBTO_OP_FLAG_SET : cbto_pkg::CBTO_OP_FLAG_CLR, 4'h0, 3'(b), 8'h00);
         esr[3'(b)] = (b < 8);
         `CHK({status_register, cyc[1:0]}, {esr, 2'h1})
      end
      repeat (4) begin
         v = rnd();
         r = {2'b01, v[1:0]};
         w = rnd();
         go(cbto_pkg::CBTO_OP_LDI, r, 3'h0, v);
         peek(r, v);
         go(cbto_pkg::CBTO_OP_MOV, 4'h2, 3'h0, 8'h00, 1'b1, r);
         peek(4'h2, v);
         go(cbto_pkg::CBTO_OP_BST, r, w[2:0], 8'h00);
         esr[6] = v[w[2:0]];
         `CHK({status_register, cyc[1:0]}, {esr, 2'h1})
         go(cbto_pkg::CBTO_OP_LDI, 4'h8, 3'h0, w);
         go(cbto_pkg::CBTO_OP_BLD, 4'h8, w[5:3], 8'h00);
         d = w;
         d[w[5:3]] = esr[6];
         peek(4'h8, d);
         io_rdata = rnd();
         go(cbto_pkg::CBTO_OP_IO_CLR, 4'h0, v[5:3], w);
         `CHK({iq.wr_en, iq.addr, iq.wdata, cyc[1:0]}, {1'b1, w[5:0], io_rdata & ~(8'h01 << v[5:3]), 2'h1})
         go(cbto_pkg::CBTO_OP_IO_SET, 4'h0, v[5:3], w);
         `CHK({iq.wr_en, iq.addr, iq.wdata, status_register}, {1'b1, w[5:0], io_rdata | (8'h01 << v[5:3]), esr})
         go(cbto_pkg::CBTO_OP_IN, 4'h9, 3'h0, v);
         `CHK({iq.rd_en, iq.addr, cyc[1:0]}, {1'b1, v[5:0], 2'h1})
         go(cbto_pkg::CBTO_OP_OUT, 4'h9, 3'h0, w);
         `CHK({iq.wr_en, iq.addr, iq.wdata, status_register}, {1'b1, w[5:0], io_rdata, esr})
         mem_rdata = rnd();
         go(cbto_pkg::CBTO_OP_LDS, 4'h3, 3'h0, w);
         `CHK({mq.rd_en, mq.addr, cyc[1:0]}, {1'b1, w, 2'h1})
         peek(4'h3, mem_rdata);
         for (int p = 0; p < 3; p++) begin
            lo = cbto_pkg::CBTO_PTR_X_LO + 4'(2 * p);
            go(cbto_pkg::CBTO_OP_LDI, lo, 3'h0, v);
            go(cbto_pkg::CBTO_OP_LDI, lo + 4'h1, 3'h0, 8'h00);
            go(cbto_pkg::CBTO_OP_LD_INC, 4'h3, 3'(p), 8'h00);
            `CHK({mq.rd_en, mq.addr, cyc[1:0]}, {1'b1, v, 2'h2})
            go(cbto_pkg::CBTO_OP_LD, 4'h3, 3'(p), 8'h00);
            `CHK({mq.rd_en, mq.addr, cyc[1:0]}, {1'b1, v + 8'h01, 2'h1})
            go(cbto_pkg::CBTO_OP_LD_DEC, 4'h3, 3'(p), 8'h00);
            `CHK({mq.rd_en, mq.addr, cyc[1:0]}, {1'b1, v, 2'h2})
            go(cbto_pkg::CBTO_OP_ST_INC, 4'h3, 3'(p), 8'h00);
            `CHK({mq.wr_en, mq.addr, mq.wdata, cyc[1:0]}, {1'b1, v, mem_rdata, 2'h1})
            go(cbto_pkg::CBTO_OP_ST_DEC, 4'h3, 3'(p), 8'h00);
            `CHK({mq.wr_en, mq.addr, mq.wdata, cyc[1:0]}, {1'b1, v, mem_rdata, 2'h2})
            go(cbto_pkg::CBTO_OP_ST, 4'h3, 3'(p), 8'h00);
            `CHK({mq.wr_en, mq.addr, mq.wdata, cyc[1:0]}, {1'b1, v, mem_rdata, 2'h1})
         end
         go(cbto_pkg::CBTO_OP_PUSH, r, 3'h0, 8'h00);
         `CHK({mq.wr_en, mq.addr, mq.wdata, cyc[1:0], stack_ptr}, {1'b1, 8'hFF, v, 2'h2, 8'hFE})
         mem_rdata = rnd();
         go(cbto_pkg::CBTO_OP_POP, 4'h8, 3'h0, 8'h00);
         `CHK({mq.rd_en, mq.addr, cyc[1:0], stack_ptr}, {1'b1, 8'hFF, 2'h2, 8'hFF})
         peek(4'h8, mem_rdata);
      end
      for (int c = 0; c < 4; c++) begin
         go(cop[c], 4'h0, 3'h0, 8'h00);
         `CHK({pls, status_register, cyc[1:0]}, {3'b100 >> c, esr, 2'h1})
      end
      test_done();
   end
endmodule : test_cpu_bit_transfer_ops
`default_nettype wire
